/* File: core/smd_mac_datapath.sv */
// two-lane simd multiply, multiply-accumulate and float sign datapath
`timescale 1ns/1ps
`default_nettype none
`include "smd_consts.svh"
module smd_mac_datapath
    import smd_pkg::*;
(
    input  wire logic              mclk_i,
    input  wire logic              resetn_i,
    input  wire logic              valid_i,
    input  wire smd_op_t           op_i,
    input  wire logic [`SMD_DW-1:0] opa_i,
    input  wire logic [`SMD_DW-1:0] opb_i,
    output logic                   valid_o,
    output logic [`SMD_DW-1:0]     result_o,
    output smd_flags_t             flags_o,
    output logic [`SMD_DW-1:0]     mac_accumulator_o
);

    // signed, saturating and fractional decode of the data type
    function automatic logic dt_signed(input smd_dtype_t d);
        dt_signed = (d != SMD_DT_USI) && (d != SMD_DT_UMI);
    endfunction : dt_signed

    function automatic logic dt_sat(input smd_dtype_t d);
        dt_sat = (d == SMD_DT_USI) || (d == SMD_DT_SSI) || (d == SMD_DT_SSF);
    endfunction : dt_sat

    // unsigned types have no fractional variant at all
    function automatic logic dt_frac(input smd_dtype_t d);
        dt_frac = (d == SMD_DT_SSF) || (d == SMD_DT_SMF);
    endfunction : dt_frac

    // 32-bit add or subtract with optional clamp; returns {overflow, sum}
    function automatic logic [32:0] add32(input logic [31:0] x, input logic [31:0] y,
                                          input logic sub, input logic sgn, input logic sat);
        logic [32:0] s;
        logic        ov;
        logic [31:0] r;
        s  = sub ? ({1'b0, x} - {1'b0, y}) : ({1'b0, x} + {1'b0, y});
        r  = s[31:0];
        if (sgn) begin
            ov = sub ? ((x[`SMD_SGN_S] != y[`SMD_SGN_S]) && (r[`SMD_SGN_S] != x[`SMD_SGN_S]))
                     : ((x[`SMD_SGN_S] == y[`SMD_SGN_S]) && (r[`SMD_SGN_S] != x[`SMD_SGN_S]));
        end else begin
            ov = s[32];
        end
        // modulo keeps the wrapped bits and raises nothing
        if (!sat) begin
            ov = 1'b0;
        end else if (ov) begin
            if (sgn) begin
                r = x[`SMD_SGN_S] ? `SMD_S32_MIN : `SMD_S32_MAX;
            end else begin
                r = sub ? 32'h0000_0000 : `SMD_U32_MAX;
            end
        end
        add32 = {ov, r};
    endfunction : add32

    // 64-bit add or subtract with optional signed clamp; returns {overflow, sum}
    function automatic logic [64:0] add64(input logic [63:0] x, input logic [63:0] y,
                                          input logic sub, input logic sat);
        logic [63:0] r;
        logic        ov;
        r  = sub ? (x - y) : (x + y);
        ov = sub ? ((x[`SMD_SGN_D] != y[`SMD_SGN_D]) && (r[`SMD_SGN_D] != x[`SMD_SGN_D]))
                 : ((x[`SMD_SGN_D] == y[`SMD_SGN_D]) && (r[`SMD_SGN_D] != x[`SMD_SGN_D]));
        if (!sat) begin
            ov = 1'b0;
        end else if (ov) begin
            r = x[`SMD_SGN_D] ? `SMD_S64_MIN : `SMD_S64_MAX;
        end
        add64 = {ov, r};
    endfunction : add64

    smd_op_t            op;
    logic               sgn;
    logic               sat;
    logic               frc;
    logic               scalar;
    logic [`SMD_DW-1:0] mul_v;   // vector product, one word per lane
    logic [1:0]         mul_ov;
    logic [`SMD_DW-1:0] mul_s;   // scalar 64-bit product of the low lane
    logic               mul_sov;
    logic [`SMD_DW-1:0] res_nxt;
    logic [`SMD_DW-1:0] acc_nxt;
    logic [1:0]         ov_nxt;
    logic               acc_we;
    logic [`SMD_DW-1:0] acc_r;
    logic [`SMD_DW-1:0] res_r;
    logic [1:0]         ov_r;
    logic               valid_r;

    // reserved op bits are dropped here so they can never steer anything
    always_comb begin
        op      = op_i;
        op.rsvd = 4'h0;
    end

    assign sgn    = dt_signed(op.dtype);
    assign sat    = dt_sat(op.dtype);
    assign frc    = dt_frac(op.dtype);
    assign scalar = (op.mform == SMD_MF_HEG) || (op.mform == SMD_MF_HOG) || (op.mform == SMD_MF_W);

    // one multiplier per lane, each lane sees only its own word
    for (genvar l = 0; l < `SMD_LANES; l++) begin : g_lane
        logic [31:0] a;
        logic [31:0] b;
        logic [15:0] ah;
        logic [15:0] bh;
        logic [31:0] ph;
        logic [63:0] pw;
        assign a = opa_i[l*`SMD_LW +: `SMD_LW];
        assign b = opb_i[l*`SMD_LW +: `SMD_LW];
        // even halfword is the upper one of the word
        assign ah = (op.mform == SMD_MF_HE || op.mform == SMD_MF_HEG) ? a[31:16] : a[15:0];
        assign bh = (op.mform == SMD_MF_HE || op.mform == SMD_MF_HEG) ? b[31:16] : b[15:0];
        assign ph = sgn ? 32'($signed(ah) * $signed(bh)) : ({16'h0000, ah} * {16'h0000, bh});
        assign pw = sgn ? 64'($signed(a) * $signed(b)) : ({32'h0, a} * {32'h0, b});

        always_comb begin
            logic [31:0] w;
            logic        o;
            w = ph;
            o = 1'b0;
            unique case (op.mform)
                SMD_MF_HE, SMD_MF_HOD, SMD_MF_HEG, SMD_MF_HOG: begin
                    if (frc) begin
                        // only -1 * -1 escapes the fractional range
                        o = (ah == `SMD_H_MIN) && (bh == `SMD_H_MIN);
                        w = {ph[30:0], 1'b0};
                    end
                end
                SMD_MF_WUP, SMD_MF_WHG: begin
                    if (frc) begin
                        o = (a == `SMD_S32_MIN) && (b == `SMD_S32_MIN);
                        w = pw[62:31];
                    end else begin
                        w = pw[63:32];
                    end
                end
                SMD_MF_WLO, SMD_MF_WLG: begin
                    // fractional low word is unsupported: integer low word is returned
                    w = pw[31:0];
                    if (!frc) begin
                        o = sgn ? (pw[63:31] != {33{pw[63]}}) : (pw[63:32] != 32'h0);
                    end
                end
                default: begin
                    w = pw[31:0];
                end
            endcase
            if (sat && o) begin
                // clamp inside this lane only
                if (!sgn) begin
                    w = `SMD_U32_MAX;
                end else if (frc || !pw[63]) begin
                    w = `SMD_S32_MAX;
                end else begin
                    w = `SMD_S32_MIN;
                end
            end
            mul_v[l*`SMD_LW +: `SMD_LW] = w;
            mul_ov[l] = sat & o;
        end
    end

    // scalar forms take the low lane and produce a 64-bit product
    always_comb begin
        mul_sov = 1'b0;
        if (op.mform == SMD_MF_W) begin
            mul_s = sgn ? 64'($signed(opa_i[31:0]) * $signed(opb_i[31:0]))
                        : ({32'h0, opa_i[31:0]} * {32'h0, opb_i[31:0]});
            if (frc) begin
                mul_sov = (opa_i[31:0] == `SMD_S32_MIN) && (opb_i[31:0] == `SMD_S32_MIN);
                mul_s   = (sat && mul_sov) ? `SMD_S64_MAX : {mul_s[62:0], 1'b0};
                mul_sov = sat & mul_sov;
            end
        end else begin
            // guarded halfword: lane product widened to 64 bits
            mul_s = sgn ? {{32{mul_v[31]}}, mul_v[31:0]} : {32'h0, mul_v[31:0]};
            mul_sov = mul_ov[0]; // a clamped guarded product must still flag
        end
    end

    // float sign operations on the shared registers; exact under IEEE rules, no rounding involved
    function automatic logic fsgn(input logic s, input smd_fpfn_t f);
        unique case (f)
            SMD_FN_ABS:  fsgn = 1'b0;
            SMD_FN_NABS: fsgn = 1'b1;
            SMD_FN_NEG:  fsgn = ~s;
            default:     fsgn = s;
        endcase
    endfunction : fsgn

    // result, accumulator and flag selection
    always_comb begin
        logic [64:0] t64;
        logic [32:0] t0;
        logic [32:0] t1;
        logic        sub;
        logic [`SMD_DW-1:0] prod;
        t64     = 65'h0;
        t0      = 33'h0;
        t1      = 33'h0;
        prod    = scalar ? mul_s : mul_v;
        res_nxt = prod;
        acc_nxt = acc_r;
        ov_nxt  = scalar ? {1'b0, mul_sov} : mul_ov;
        acc_we  = 1'b0;
        sub     = (op.aopt == SMD_AO_SUB) || (op.aopt == SMD_AO_ANW);
        unique case (op.cls)
            SMD_CL_MUL: begin
                unique case (op.aopt)
                    SMD_AO_NONE: begin
                        acc_we = 1'b0;
                    end
                    SMD_AO_A: begin
                        acc_we  = 1'b1;
                        acc_nxt = prod;
                    end
                    SMD_AO_ADD, SMD_AO_SUB: begin
                        t64     = add64(acc_r, prod, sub, sat & sgn);
                        acc_we  = 1'b1;
                        acc_nxt = t64[63:0];
                        ov_nxt  = {1'b0, t64[64] | ov_nxt[0]};
                    end
                    SMD_AO_AAW, SMD_AO_ANW: begin
                        t0      = add32(acc_r[31:0], prod[31:0], sub, sgn, sat);
                        t1      = add32(acc_r[63:32], prod[63:32], sub, sgn, sat);
                        acc_we  = 1'b1;
                        acc_nxt = {t1[31:0], t0[31:0]};
                        ov_nxt  = {t1[32], t0[32]} | ov_nxt;
                    end
                    default: begin
                        acc_we = 1'b0;
                    end
                endcase
            end
            SMD_CL_ACCADD, SMD_CL_ACCSUB: begin
                sub     = (op.cls == SMD_CL_ACCSUB);
                t0      = add32(acc_r[31:0], opa_i[31:0], sub, sgn, sat);
                t1      = add32(acc_r[63:32], opa_i[63:32], sub, sgn, sat);
                acc_we  = 1'b1;
                acc_nxt = {t1[31:0], t0[31:0]};
                ov_nxt  = {t1[32], t0[32]};
            end
            SMD_CL_FP: begin
                ov_nxt  = 2'b00;
                res_nxt = opa_i;
                unique case (op.fprec)
                    SMD_FP_SS: begin
                        res_nxt[`SMD_SGN_S] = fsgn(opa_i[`SMD_SGN_S], op.fpfn);
                    end
                    SMD_FP_VS: begin
                        res_nxt[`SMD_SGN_S] = fsgn(opa_i[`SMD_SGN_S], op.fpfn);
                        res_nxt[`SMD_SGN_D] = fsgn(opa_i[`SMD_SGN_D], op.fpfn);
                    end
                    SMD_FP_SD: begin
                        res_nxt[`SMD_SGN_D] = fsgn(opa_i[`SMD_SGN_D], op.fpfn);
                    end
                    default: begin
                        res_nxt = opa_i;
                    end
                endcase
            end
            default: begin
                acc_we = 1'b0;
            end
        endcase
        // an accumulating operation writes the new accumulator to its destination too
        if (acc_we) begin
            res_nxt = acc_nxt;
        end
    end

    // accumulator: read by the very next operation, so no software staging is needed
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            acc_r <= `SMD_ACC_RST;
        end else if (valid_i && acc_we) begin
            acc_r <= acc_nxt;
        end
    end

    // destination result and overflow flags, held until the next operation
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            res_r   <= 64'h0;
            ov_r    <= 2'b00;
            valid_r <= 1'b0;
        end else begin
            valid_r <= valid_i;
            if (valid_i) begin
                res_r <= res_nxt;
                ov_r  <= ov_nxt;
            end
        end
    end

    assign valid_o           = valid_r;
    assign result_o          = res_r;
    assign flags_o           = '{rsvd: 6'h00, ovf: ov_r};
    assign mac_accumulator_o = acc_r;

endmodule : smd_mac_datapath
`default_nettype wire

/* File: pkg/smd_consts.svh */
// constants of the two-lane multiply-accumulate datapath
// Notes on behaviour
// - Reserved bits of the op word and of the flag output are ignored on input and always read as zero.
// - Each 64-bit operand is two 32-bit lanes; vector operations act on both lanes at once, guarded halfword and full word forms on the low lane only.
// - A dedicated accumulator holds multiply-accumulate results so a dependent operation can follow at once.
// - Halfword forms multiply 16 by 16 into 32 bits, even or odd halfword, per lane when plain and in the low lane widened to 64 bits when guarded.
// - Word forms multiply 32 by 32; high and low keep 32 product bits and the full form keeps all 64.
// - Operands may be signed, unsigned or signed fractional, each with saturating or modulo results.
// - Unsigned operands have no fractional mode since unsigned integer and fractional results match.
// - Accumulate options are write, add, subtract, add per word and subtract per word into the accumulator.
// - Low-word fractional forms are unsupported and give a bounded but unspecified result.
// - The datapath also adds an operand to, or subtracts it from, the accumulator.
// - Float operations use the same widened registers: scalar single, vector single and scalar double.
// - Float operations give results compatible with the IEEE binary floating-point standard.
// - Modulo types discard overflow bits and never flag or saturate.
// - Saturating types replace an overflowing result with the largest or smallest value of the type; unsigned 64-bit accumulate add and subtract wrap.
// - Every accumulating operation also copies the accumulator result to its 64-bit destination.
`ifndef SMD_CONSTS_SVH
`define SMD_CONSTS_SVH
`define SMD_DW        64
`define SMD_LW        32
`define SMD_HW        16
`define SMD_LANES     2
`define SMD_S32_MAX   32'h7fff_ffff
`define SMD_S32_MIN   32'h8000_0000
`define SMD_U32_MAX   32'hffff_ffff
`define SMD_S64_MAX   64'h7fff_ffff_ffff_ffff
`define SMD_S64_MIN   64'h8000_0000_0000_0000
`define SMD_H_MIN     16'h8000
`define SMD_SGN_S     31
`define SMD_SGN_D     63
`define SMD_ACC_RST   64'h0000_0000_0000_0000
`endif

/* File: pkg/smd_pkg.sv */
// types of the two-lane multiply-accumulate datapath
package smd_pkg;
    typedef enum logic [3:0] {
        SMD_MF_HE  = 4'h0, SMD_MF_HOD = 4'h1, SMD_MF_HEG = 4'h2, SMD_MF_HOG = 4'h3,
        SMD_MF_WUP = 4'h4, SMD_MF_WLO = 4'h5, SMD_MF_WHG = 4'h6, SMD_MF_WLG = 4'h7,
        SMD_MF_W   = 4'h8
    } smd_mform_t;
    typedef enum logic [2:0] {
        SMD_DT_USI = 3'h0, SMD_DT_UMI = 3'h1, SMD_DT_SSI = 3'h2,
        SMD_DT_SSF = 3'h3, SMD_DT_SMI = 3'h4, SMD_DT_SMF = 3'h5
    } smd_dtype_t;
    typedef enum logic [2:0] {
        SMD_AO_NONE = 3'h0, SMD_AO_A = 3'h1, SMD_AO_ADD = 3'h2,
        SMD_AO_SUB = 3'h3, SMD_AO_AAW = 3'h4, SMD_AO_ANW = 3'h5
    } smd_aopt_t;
    typedef enum logic [1:0] {
        SMD_CL_MUL = 2'h0, SMD_CL_ACCADD = 2'h1, SMD_CL_ACCSUB = 2'h2, SMD_CL_FP = 2'h3
    } smd_class_t;
    typedef enum logic [1:0] {
        SMD_FP_SS = 2'h0, SMD_FP_VS = 2'h1, SMD_FP_SD = 2'h2
    } smd_fprec_t;
    typedef enum logic [1:0] {
        SMD_FN_ABS = 2'h0, SMD_FN_NABS = 2'h1, SMD_FN_NEG = 2'h2
    } smd_fpfn_t;
    typedef struct packed {
        logic [3:0] rsvd;   // ignored on input
        smd_class_t cls;
        smd_mform_t mform;
        smd_dtype_t dtype;
        smd_aopt_t  aopt;
        smd_fprec_t fprec;
        smd_fpfn_t  fpfn;
    } smd_op_t;
    typedef struct packed {
        logic [5:0] rsvd;   // always zero
        logic [1:0] ovf;    // per lane, [1] upper word
    } smd_flags_t;
endpackage : smd_pkg

/* File: verif/smd_mac_datapath_checker.sv */
// port assertions for the two-lane multiply-accumulate datapath
`timescale 1ns/1ps
`default_nettype none
module smd_mac_datapath_checker
    import smd_pkg::*;
(
    input wire logic        mclk_i,
    input wire logic        resetn_i,
    input wire logic        valid_i,
    input wire smd_op_t     op_i,
    input wire logic [63:0] opa_i,
    input wire logic [63:0] opb_i,
    input wire logic        valid_o,
    input wire logic [63:0] result_o,
    input wire smd_flags_t  flags_o,
    input wire logic [63:0] mac_accumulator_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    // helpers: lane products and per-word sums, carries cut at the lane edge
    wire logic        mul_w = valid_i && op_i.cls == SMD_CL_MUL;
    wire logic [31:0] ev1   = opa_i[63:48] * opb_i[63:48];
    wire logic [31:0] ev0   = opa_i[31:16] * opb_i[31:16];
    wire logic [63:0] wsum  = {mac_accumulator_o[63:32] + opa_i[63:32], mac_accumulator_o[31:0] + opa_i[31:0]};

    property p_answer; valid_i |=> valid_o; endproperty
    a_answer: assert property (p_answer) else $error("no answer one cycle after an op");
    property p_quiet; !valid_i |=> !valid_o; endproperty
    a_quiet: assert property (p_quiet) else $error("answer without an op");
    property p_rsvd; flags_o.rsvd == 6'h00; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved flag bits not zero");
    property p_hold; !valid_i |=> $stable(result_o) && $stable(mac_accumulator_o); endproperty
    a_hold: assert property (p_hold) else $error("outputs moved without an op");
    property p_copy; mul_w && op_i.aopt != SMD_AO_NONE |=> result_o == mac_accumulator_o; endproperty
    a_copy: assert property (p_copy) else $error("result differs from accumulator");
    property p_noacc; mul_w && op_i.aopt == SMD_AO_NONE |=> $stable(mac_accumulator_o); endproperty
    a_noacc: assert property (p_noacc) else $error("accumulator written by plain multiply");
    property p_modulo;
        mul_w && op_i.dtype inside {SMD_DT_UMI, SMD_DT_SMI, SMD_DT_SMF} |=> flags_o.ovf == 2'b00;
    endproperty
    a_modulo: assert property (p_modulo) else $error("modulo type raised a flag");
    property p_even;
        mul_w && op_i.mform == SMD_MF_HE && op_i.dtype == SMD_DT_UMI && op_i.aopt == SMD_AO_NONE
            |=> result_o == {$past(ev1), $past(ev0)};
    endproperty
    a_even: assert property (p_even) else $error("even halfword product wrong");
    property p_wadd;
        valid_i && op_i.cls == SMD_CL_ACCADD && op_i.dtype == SMD_DT_UMI |=> mac_accumulator_o == $past(wsum);
    endproperty
    a_wadd: assert property (p_wadd) else $error("per-word operand add wrong");
    property p_neg;
        valid_i && op_i.cls == SMD_CL_FP && op_i.fprec == SMD_FP_SD && op_i.fpfn == SMD_FN_NEG
            |=> result_o == ($past(opa_i) ^ 64'h8000_0000_0000_0000);
    endproperty
    a_neg: assert property (p_neg) else $error("double negate wrong");
    // main scenarios reached
    c_b2b: cover property (valid_i ##1 valid_i ##1 valid_i);
    c_sat: cover property (valid_o && flags_o.ovf != 2'b00);
    c_addacc: cover property (mul_w && op_i.aopt == SMD_AO_ADD);
endmodule : smd_mac_datapath_checker
bind smd_mac_datapath smd_mac_datapath_checker smd_mac_datapath_checker_i (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .valid_i(valid_i), .op_i(op_i), .opa_i(opa_i), .opb_i(opb_i), .valid_o(valid_o), .result_o(result_o),
    .flags_o(flags_o), .mac_accumulator_o(mac_accumulator_o));
`default_nettype wire

/* File: verif/smd_issue_model.sv */
// issuing side model: drives ops and operands into the datapath
`timescale 1ns/1ps
`default_nettype none
module smd_issue_model
    import smd_pkg::*;
(
    input  wire logic        mclk_i,
    output var  logic        valid_o,
    output var  smd_op_t     op_o,
    output var  logic [63:0] opa_o,
    output var  logic [63:0] opb_o
);
    initial begin
        valid_o = 1'b0;
        op_o = '0;
        opa_o = 64'h0;
        opb_o = 64'h0;
    end
    // one op per call just after the edge; calls may follow back to back
    task automatic issue(input smd_op_t op, input logic [63:0] a, input logic [63:0] b);
        @(posedge mclk_i);
        #1;
        valid_o = 1'b1;
        op_o = op;
        opa_o = a;
        opb_o = b;
    endtask : issue
    // operands invalid now: show the inverse so a stale copy cannot pass
    task automatic idle();
        @(posedge mclk_i);
        #1;
        valid_o = 1'b0;
        opa_o = ~opa_o;
        opb_o = ~opb_o;
    endtask : idle
endmodule : smd_issue_model
`default_nettype wire

/* File: verif/smd_mac_datapath_tb_top.sv */
// self-checking bench for the two-lane multiply-accumulate datapath
`timescale 1ns/1ps
`default_nettype none
module smd_mac_datapath_tb_top
    import smd_pkg::*;
;
    localparam logic [63:0] SA = 64'h4000_0000_8000_0000;
    localparam logic [63:0] WA = 64'h8000_0000_ffff_ffff;
    localparam logic [63:0] WB = 64'h0000_0004_0000_0002;
    localparam logic [63:0] FA = 64'h8000_0002_0007_0009;
    localparam logic [63:0] FB = 64'h0004_0003_0006_0005;
    logic        mclk_i;
    logic        resetn_i;
    logic        valid_i;
    smd_op_t     op_i;
    logic [63:0] opa_i;
    logic [63:0] opb_i;
    logic        valid_o;
    logic [63:0] result_o;
    smd_flags_t  flags_o;
    logic [63:0] acc_o;
    int          miscompares = 0;
    int          total_checks = 0;

    smd_issue_model smd_issue_model_i (.mclk_i(mclk_i), .valid_o(valid_i), .op_o(op_i), .opa_o(opa_i),
        .opb_o(opb_i));
    smd_mac_datapath smd_mac_datapath_i (.mclk_i(mclk_i), .resetn_i(resetn_i), .valid_i(valid_i), .op_i(op_i),
        .opa_i(opa_i), .opb_i(opb_i), .valid_o(valid_o), .result_o(result_o), .flags_o(flags_o),
        .mac_accumulator_o(acc_o));

    // 100 MHz core clock
    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end

    task automatic finish_test();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test

    task automatic chk64(input string what, input logic [63:0] want, input logic [63:0] got);
        total_checks++;
        if (got !== want) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, want, got);
        end
    endtask : chk64

    task automatic chkf(input string what, input logic [1:0] ovf, input smd_flags_t got);
        total_checks++;
        if (got !== {6'h00, ovf}) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, {6'h00, ovf}, got);
        end
    endtask : chkf

    // reserved op bits set on purpose: they must be ignored
    function automatic smd_op_t mk(smd_class_t c, smd_mform_t m, smd_dtype_t d, smd_aopt_t a, smd_fprec_t p,
                                   smd_fpfn_t f);
        return '{rsvd: 4'hf, cls: c, mform: m, dtype: d, aopt: a, fprec: p, fpfn: f};
    endfunction : mk

    function automatic smd_op_t mul(smd_mform_t m, smd_dtype_t d, smd_aopt_t a);
        return mk(SMD_CL_MUL, m, d, a, SMD_FP_SS, SMD_FN_ABS);
    endfunction : mul

    // unsigned modulo reference; guarded halfword forms keep lane0 only
    function automatic logic [63:0] umi_ref(smd_mform_t m, logic [63:0] a, logic [63:0] b);
        logic [63:0] p1;
        logic [63:0] p0;
        logic [31:0] e1;
        logic [31:0] e0;
        logic [31:0] o1;
        logic [31:0] o0;
        p1 = a[63:32] * b[63:32];
        p0 = a[31:0] * b[31:0];
        e1 = a[63:48] * b[63:48];
        e0 = a[31:16] * b[31:16];
        o1 = a[47:32] * b[47:32];
        o0 = a[15:0] * b[15:0];
        case (m)
            SMD_MF_HE: return {e1, e0};
            SMD_MF_HOD: return {o1, o0};
            SMD_MF_HEG: return 64'(e0);
            SMD_MF_HOG: return 64'(o0);
            SMD_MF_WUP, SMD_MF_WHG: return {p1[63:32], p0[63:32]};
            SMD_MF_WLO, SMD_MF_WLG: return {p1[31:0], p0[31:0]};
            default: return p0;
        endcase
    endfunction : umi_ref

    task automatic do_reset();
        @(posedge mclk_i);
        #1;
        resetn_i = 1'b0;
        repeat (16) @(posedge mclk_i);
        #1;
        resetn_i = 1'b1;
    endtask : do_reset

    task automatic one(input smd_op_t op, input logic [63:0] a, input logic [63:0] b, input logic [63:0] want,
                       input logic [1:0] ovf);
        smd_issue_model_i.issue(op, a, b);
        smd_issue_model_i.idle();
        chk64("valid", 64'h1, 64'(valid_o));
        chk64("result", want, result_o);
        chkf("flags", ovf, flags_o);
    endtask : one

    task automatic s_reset_values();
        chk64("valid", 64'h0, 64'(valid_o));
        chk64("result", 64'h0, result_o);
        chk64("accumulator", 64'h0, acc_o);
        chkf("flags", 2'b00, flags_o);
    endtask : s_reset_values

    task automatic s_forms();
        for (int i = 0; i < 9; i++) begin
            one(mul(smd_mform_t'(i), SMD_DT_UMI, SMD_AO_NONE), FA, FB, umi_ref(smd_mform_t'(i), FA, FB), 2'b00);
        end
    endtask : s_forms

    // overflow in one lane (signed, fractional), in both lanes (unsigned), and no overflow
    task automatic s_sat();
        one(mul(SMD_MF_HE, SMD_DT_SSF, SMD_AO_NONE), SA, SA, 64'h2000_0000_7fff_ffff, 2'b01);
        one(mul(SMD_MF_HE, SMD_DT_SMF, SMD_AO_NONE), SA, SA, 64'h2000_0000_8000_0000, 2'b00);
        one(mul(SMD_MF_WLO, SMD_DT_SSI, SMD_AO_NONE), WA, WB, 64'h8000_0000_ffff_fffe, 2'b10);
        one(mul(SMD_MF_WLO, SMD_DT_USI, SMD_AO_NONE), WA, WB, 64'hffff_ffff_ffff_ffff, 2'b11);
        one(mul(SMD_MF_HEG, SMD_DT_SSF, SMD_AO_NONE), SA, SA, 64'h0000_0000_7fff_ffff, 2'b01);
        one(mul(SMD_MF_HOG, SMD_DT_SSI, SMD_AO_NONE), WA, WB, 64'hffff_ffff_ffff_fffe, 2'b00);
        one(mul(SMD_MF_W, SMD_DT_SMI, SMD_AO_NONE), WA, WB, 64'hffff_ffff_ffff_fffe, 2'b00);
    endtask : s_sat

    // dependent ops issued every cycle; in the per-word steps lane0 wraps, lane1 must not see it
    task automatic s_accum();
        smd_aopt_t   ao[5] = '{SMD_AO_A, SMD_AO_ADD, SMD_AO_SUB, SMD_AO_AAW, SMD_AO_ANW};
        logic [63:0] a = 64'h0003_0000_ffff_0000;
        logic [63:0] p = 64'h0000_0009_fffe_0001;
        logic [63:0] acc = 64'h0;
        logic [63:0] prev = 64'h0;
        smd_op_t     op;
        for (int i = 0; i < 7; i++) begin
            op = (i < 5) ? mul(SMD_MF_HE, SMD_DT_UMI, ao[i]) : mk((i == 5) ? SMD_CL_ACCADD : SMD_CL_ACCSUB,
                 SMD_MF_HE, SMD_DT_UMI, SMD_AO_NONE, SMD_FP_SS, SMD_FN_ABS);
            case (i)
                0: acc = p;
                1: acc = acc + p;
                2: acc = acc - p;
                3: acc = {acc[63:32] + p[63:32], acc[31:0] + p[31:0]};
                4: acc = {acc[63:32] - p[63:32], acc[31:0] - p[31:0]};
                5: acc = {acc[63:32] + a[63:32], acc[31:0] + a[31:0]};
                default: acc = {acc[63:32] - a[63:32], acc[31:0] - a[31:0]};
            endcase
            smd_issue_model_i.issue(op, a, a);
            if (i > 0) chk64("accumulator", prev, acc_o);
            if (i > 0) chk64("result", prev, result_o);
            prev = acc;
        end
        smd_issue_model_i.idle();
        chk64("accumulator", prev, acc_o);
    endtask : s_accum

    // sign ops on every precision; scalar single judged on the low word only
    task automatic s_fp();
        logic [63:0] a = 64'h0123_4567_89ab_cdef;
        logic [63:0] m;
        logic [63:0] want;
        logic [63:0] keep;
        for (int p = 0; p < 3; p++) begin
            for (int f = 0; f < 3; f++) begin
                m = (p == 0) ? 64'h8000_0000 : (p == 1) ? 64'h8000_0000_8000_0000 : 64'h8000_0000_0000_0000;
                keep = (p == 0) ? 64'hffff_ffff : 64'hffff_ffff_ffff_ffff;
                want = (f == 0) ? (a & ~m) : (f == 1) ? (a | m) : (a ^ m);
                smd_issue_model_i.issue(mk(SMD_CL_FP, SMD_MF_HE, SMD_DT_UMI, SMD_AO_NONE, smd_fprec_t'(p),
                                           smd_fpfn_t'(f)), a, 64'h0);
                smd_issue_model_i.idle();
                chk64("float sign", want & keep, result_o & keep);
            end
        end
    endtask : s_fp

    initial begin
        resetn_i = 1'b0;
        do_reset();
        s_reset_values();
        s_forms();
        s_sat();
        s_accum();
        do_reset();
        s_reset_values();
        s_fp();
        finish_test();
    end

    // watchdog far beyond the roughly 92 cycles the run needs
    initial begin
        #20000;
        miscompares++;
        finish_test();
    end
endmodule : smd_mac_datapath_tb_top
`default_nettype wire
